// ### hw/se_client_pkg.sv
// Shared constants for the secure element bus client
package se_client_pkg;
	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int MCLK_HZ = 10_000_000;
	localparam int MCLK_PER_US = MCLK_HZ / 1_000_000;
	localparam int WAKE_LOW_TIME_US = 60;
	localparam int WAKE_HIGH_DELAY_US = 1500;
	localparam int WAKE_LOW_CYCLES = WAKE_LOW_TIME_US * MCLK_PER_US;
	localparam int WAKE_HIGH_CYCLES = WAKE_HIGH_DELAY_US * MCLK_PER_US;
	localparam int WAKE_CNT_W = 10;
	localparam int DELAY_CNT_W = 24;
	// ****************************************
	// Word address codes
	// ****************************************
	localparam logic [7:0] WORD_RESET = 8'h00;
	localparam logic [7:0] WORD_SLEEP = 8'h01;
	localparam logic [7:0] WORD_IDLE = 8'h02;
	localparam logic [7:0] WORD_COMMAND = 8'h03;
	// ****************************************
	// Input buffer and bus address
	// ****************************************
	localparam int BUF_DEPTH = 64;
	localparam int PTR_W = 7;
	localparam int IDX_W = 6;
	localparam logic [6:0] BUS_ADDRESS_RESET = 7'h30;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_ACK_END = 4'h9;
	// ****************************************
	// Link to core event kinds
	// ****************************************
	typedef enum logic [1:0] {EV_WORD, EV_DATA, EV_STOP} event_e;
endpackage : se_client_pkg

// ### hw/wake_detector.sv
// Long SDA low pulse detector for leaving low power
`timescale 1ns/1ps
`default_nettype none
module wake_detector
	import se_client_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sda_sync,
	input wire logic armed,
	output logic wake
);
	logic [WAKE_CNT_W-1:0] low_cnt;
	logic sda_prev;
	logic long_low;

	assign long_low = (low_cnt >= WAKE_CNT_W'(WAKE_LOW_CYCLES));
	// Fires on the rising edge only; counting is saturated so slow zero bytes also wake
	assign wake = armed && sda_sync && !sda_prev && long_low;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			low_cnt <= '0;
		end else if (sda_sync) begin
			low_cnt <= '0;
		end else if (!long_low) begin
			low_cnt <= low_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sda_prev <= 1'b1;
		end else begin
			sda_prev <= sda_sync;
		end
	end
endmodule : wake_detector
`default_nettype wire

// ### hw/i2c_link_engine.sv
// Bit, start, stop and acknowledge engine on the link clock
`timescale 1ns/1ps
`default_nettype none
module i2c_link_engine
	import se_client_pkg::*;
#(
	parameter logic [6:0] BUS_ADDRESS = BUS_ADDRESS_RESET
) (
	input wire logic link_clk,
	input wire logic reset_n,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic enable_async,
	output logic sda_oe,
	output logic ev_toggle,
	output event_e ev_kind,
	output logic [7:0] ev_byte
);
	typedef enum {L_IDLE, L_ADDR, L_WORD, L_DATA, L_IGNORE} link_e;
	link_e st;
	logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, en_m, en_s;
	logic start_c, stop_c, rise, fall;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic addr_hit;

	// ****************************************
	// Synchronisers
	// ****************************************
	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			{scl_m, scl_s, scl_p} <= 3'h7;
			{sda_m, sda_s, sda_p} <= 3'h7;
			{en_m, en_s} <= 2'h0;
		end else begin
			{scl_m, scl_s, scl_p} <= {scl_in, scl_m, scl_s};
			{sda_m, sda_s, sda_p} <= {sda_in, sda_m, sda_s};
			{en_m, en_s} <= {enable_async, en_m};
		end
	end

	assign start_c = scl_s && scl_p && sda_p && !sda_s;
	assign stop_c = scl_s && scl_p && !sda_p && sda_s;
	assign rise = scl_s && !scl_p;
	assign fall = !scl_s && scl_p;
	// Reads are never answered: no data is ready for them here
	assign addr_hit = (shift[7:1] == BUS_ADDRESS) && !shift[0];

	// ****************************************
	// Transaction state
	// ****************************************
	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= L_IDLE;
			bit_cnt <= '0;
			shift <= '0;
			sda_oe <= 1'b0;
			ev_toggle <= 1'b0;
			ev_kind <= EV_STOP;
			ev_byte <= '0;
		end else if (!en_s) begin
			st <= L_IDLE;
			sda_oe <= 1'b0;
		end else if (start_c) begin
			st <= L_ADDR;
			bit_cnt <= '0;
			sda_oe <= 1'b0;
		end else if (stop_c) begin
			if (st == L_WORD || st == L_DATA) begin
				ev_kind <= EV_STOP;
				ev_toggle <= !ev_toggle;
			end
			st <= L_IDLE;
			sda_oe <= 1'b0;
		end else if (st != L_IDLE && st != L_IGNORE) begin
			if (rise && bit_cnt < BIT_ACK) begin
				shift <= {shift[6:0], sda_s};
				bit_cnt <= bit_cnt + 1'b1;
			end else if (fall && bit_cnt == BIT_ACK) begin
				bit_cnt <= BIT_ACK_END;
				sda_oe <= (st != L_ADDR) || addr_hit;
				if (st != L_ADDR) begin
					ev_kind <= (st == L_WORD) ? EV_WORD : EV_DATA;
					ev_byte <= shift;
					ev_toggle <= !ev_toggle;
				end
			end else if (fall && bit_cnt == BIT_ACK_END) begin
				bit_cnt <= '0;
				sda_oe <= 1'b0;
				case (st)
					L_ADDR: st <= addr_hit ? L_WORD : L_IGNORE;
					L_WORD: st <= L_DATA;
					default: st <= st;
				endcase
			end
		end
	end
endmodule : i2c_link_engine
`default_nettype wire

// ### hw/secure_element_i2c_client.sv
// Bus client front end: wake, word address handling and command input buffer
//
// Behaviour
// - Wake on SDA rise after long low; accept commands after wake-high delay.
// - While asleep, ignore everything but a valid wake.
// - SCL ignored asleep, idle and during wake; enabled within wake-high delay. Here the link is enabled only after the delay has run out.
// - Wake pulse while already awake has no effect.
// - Data bit is SDA stable across an SCL pulse; changes only while low.
// - SDA fall with SCL high is start, before every command.
// - SDA rise with SCL high ends transaction; complete command starts execution.
// - Receiver pulls SDA low on ninth clock to acknowledge a byte.
// - Receiver may leave SDA high on ninth clock instead.
// - Respond only on matching seven address bits with write flag zero.
// - Command code stores following bytes at successive buffer positions.
// - Reset code returns buffer address counter to start.
// - Sleep code enters sleep, clears volatile state, ignores bus until wake.
// - Idle code enters idle, keeps key and digest contents, ignores bus.
// - Group is count, packet and two-byte checksum over both.
// - Group may span writes; bytes beyond count discarded until execution ends.
// - Device drives SDA only open-drain.
// - No acknowledge of read address when busy, idle, asleep or partial.
`timescale 1ns/1ps
`default_nettype none
module secure_element_i2c_client
	import se_client_pkg::*;
#(
	parameter logic [6:0] BUS_ADDRESS = BUS_ADDRESS_RESET,
	parameter int WAKE_HIGH_COUNT = WAKE_HIGH_CYCLES
) (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic LINK_CLK,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic CMD_DONE,
	input wire logic [IDX_W-1:0] CMD_RD_INDEX,
	output logic [7:0] CMD_RD_DATA,
	output logic [PTR_W-1:0] CMD_LENGTH,
	output logic CMD_START,
	output logic BUSY,
	output logic READY,
	output logic SLEEPING,
	output logic IDLING,
	output logic VOLATILE_CLEAR
);
	typedef enum {ST_SLEEP, ST_IDLE, ST_WAKING, ST_AWAKE, ST_BUSY} core_e;
	core_e st;
	logic sda_m, sda_s;
	logic wake;
	logic link_enable;
	logic ev_toggle;
	event_e ev_kind;
	logic [7:0] ev_byte;
	logic t1, t2, t3;
	logic ev_pulse;
	logic [DELAY_CNT_W-1:0] delay_cnt;
	logic [7:0] word;
	logic [7:0] buffer [BUF_DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic take_byte, group_done;
	logic ev_valid;
	event_e kind_held;
	logic [7:0] byte_held;
	logic word_ev, data_ev, stop_ev;
	logic stop_awake, stop_sleep, stop_idle, stop_group;

	function automatic logic group_complete(input logic [PTR_W-1:0] ptr, input logic [7:0] count);
		group_complete = (ptr != '0) && ({1'b0, ptr} >= count);
	endfunction : group_complete

	// Each event kind is decoded in one place, through this function
	function automatic logic event_is(input logic valid, input event_e kind, input event_e want);
		event_is = valid && (kind == want);
	endfunction : event_is

	// ****************************************
	// Wake path on the core clock
	// ****************************************
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			{sda_m, sda_s} <= 2'h3;
		end else begin
			{sda_m, sda_s} <= {SDA_IN, sda_m};
		end
	end

	wake_detector u_wake (
		.clk(MCLK),
		.reset_n(RESET_N),
		.sda_sync(sda_s),
		.armed(st == ST_SLEEP || st == ST_IDLE),
		.wake(wake)
	);

	// ****************************************
	// Link engine and event crossing
	// ****************************************
	// Link stays dark until the wake-high delay has run out; a flop keeps decode glitches off the synchroniser
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			link_enable <= 1'b0;
		end else begin
			link_enable <= (st == ST_AWAKE) || (st == ST_BUSY);
		end
	end

	i2c_link_engine #(
		.BUS_ADDRESS(BUS_ADDRESS)
	) u_link (
		.link_clk(LINK_CLK),
		.reset_n(RESET_N),
		.scl_in(SCL_IN),
		.sda_in(SDA_IN),
		.enable_async(link_enable),
		.sda_oe(SDA_OE),
		.ev_toggle(ev_toggle),
		.ev_kind(ev_kind),
		.ev_byte(ev_byte)
	);

	assign SDA_OUT = 1'b0;

	// Kind and byte hold at least until after the ninth clock, so they are stable when the toggle lands
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			{t1, t2, t3} <= 3'h0;
		end else begin
			{t1, t2, t3} <= {ev_toggle, t1, t2};
		end
	end
	assign ev_pulse = t2 ^ t3;

	// ****************************************
	// Event capture
	// ****************************************
	// Kind and byte are read by one flop each, on the cycle the toggle lands
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ev_valid <= 1'b0;
		end else begin
			ev_valid <= ev_pulse;
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			kind_held <= EV_STOP;
			byte_held <= '0;
		end else if (ev_pulse) begin
			kind_held <= ev_kind;
			byte_held <= ev_byte;
		end
	end

	// ****************************************
	// Event decode
	// ****************************************
	assign word_ev = event_is(ev_valid, kind_held, EV_WORD);
	assign data_ev = event_is(ev_valid, kind_held, EV_DATA);
	assign stop_ev = event_is(ev_valid, kind_held, EV_STOP);
	assign stop_awake = stop_ev && (st == ST_AWAKE);
	assign stop_sleep = stop_awake && (word == WORD_SLEEP);
	assign stop_idle = stop_awake && (word == WORD_IDLE);
	assign stop_group = stop_awake && !stop_sleep && !stop_idle && group_done;

	// ****************************************
	// Device state
	// ****************************************
	assign group_done = group_complete(wr_ptr, buffer[0]);
	assign take_byte = data_ev && word == WORD_COMMAND && st == ST_AWAKE
		&& !group_done && wr_ptr < PTR_W'(BUF_DEPTH);

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st <= ST_SLEEP;
		end else begin
			case (st)
				ST_SLEEP, ST_IDLE: begin
					if (wake) begin
						st <= ST_WAKING;
					end
				end
				ST_WAKING: begin
					if (delay_cnt == '0) begin
						st <= ST_AWAKE;
					end
				end
				ST_AWAKE: begin
					if (stop_sleep) begin
						st <= ST_SLEEP;
					end else if (stop_idle) begin
						st <= ST_IDLE;
					end else if (stop_group) begin
						st <= ST_BUSY;
					end
				end
				ST_BUSY: begin
					if (CMD_DONE) begin
						st <= ST_AWAKE;
					end
				end
				default: st <= ST_SLEEP;
			endcase
		end
	end

	// Loaded on the wake edge so the count starts together with the waking state
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			delay_cnt <= '0;
		end else if (wake) begin
			delay_cnt <= DELAY_CNT_W'(WAKE_HIGH_COUNT - 1);
		end else if (st == ST_WAKING && delay_cnt != '0) begin
			delay_cnt <= delay_cnt - 1'b1;
		end
	end

	// Word address of the current write; cleared at stop so each write must name its purpose
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			word <= WORD_RESET;
		end else if (word_ev) begin
			word <= byte_held;
		end else if (stop_ev) begin
			word <= WORD_RESET;
		end
	end

	// ****************************************
	// Command input buffer
	// ****************************************
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wr_ptr <= '0;
		end else if (st == ST_BUSY && CMD_DONE) begin
			wr_ptr <= '0;
		end else if (st == ST_AWAKE && word_ev && byte_held == WORD_RESET) begin
			wr_ptr <= '0;
		end else if (stop_sleep) begin
			wr_ptr <= '0;
		end else if (take_byte) begin
			wr_ptr <= wr_ptr + 1'b1;
		end
	end

	// Sleep wipes the stored bytes as well; idle leaves them for the next wake
	generate
		for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_buf
			always_ff @(posedge MCLK or negedge RESET_N) begin
				if (!RESET_N) begin
					buffer[i] <= '0;
				end else if (stop_sleep) begin
					buffer[i] <= '0;
				end else if (take_byte && wr_ptr == PTR_W'(i)) begin
					buffer[i] <= byte_held;
				end
			end
		end
	endgenerate

	// ****************************************
	// Outputs toward the command engine
	// ****************************************
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CMD_START <= 1'b0;
		end else begin
			CMD_START <= stop_group;
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			VOLATILE_CLEAR <= 1'b0;
		end else begin
			VOLATILE_CLEAR <= stop_sleep;
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CMD_RD_DATA <= '0;
		end else begin
			CMD_RD_DATA <= buffer[CMD_RD_INDEX];
		end
	end

	// ****************************************
	// Status outputs
	// ****************************************
	assign CMD_LENGTH = wr_ptr;
	assign BUSY = (st == ST_BUSY);
	assign READY = (st == ST_AWAKE);
	assign SLEEPING = (st == ST_SLEEP);
	assign IDLING = (st == ST_IDLE);
endmodule : secure_element_i2c_client
`default_nettype wire

// ### test/se_client_properties.sv
// Port-level checks for the secure element bus client
`timescale 1ns/1ps
`default_nettype none
module se_client_properties
	import se_client_pkg::*;
#(
	parameter int WAKE_HIGH_COUNT = 20
) (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic LINK_CLK,
	input wire logic SCL_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	input wire logic CMD_DONE,
	input wire logic [PTR_W-1:0] CMD_LENGTH,
	input wire logic CMD_START,
	input wire logic BUSY,
	input wire logic READY,
	input wire logic SLEEPING,
	input wire logic IDLING,
	input wire logic VOLATILE_CLEAR
);
	// ****************************************
	// Sequences
	// ****************************************
	// Ready lands the nominal count after leaving sleep or idle; the window allows a few cycles either side
	localparam int GAP_MIN = WAKE_HIGH_COUNT - 9;
	localparam int GAP_MAX = WAKE_HIGH_COUNT - 3;
	sequence s_leave;
		$fell(SLEEPING || IDLING);
	endsequence
	sequence s_ready;
		!READY [*8] ##[GAP_MIN:GAP_MAX] READY;
	endsequence
	sequence s_ack;
		!SCL_IN ##1 SDA_OE [*4];
	endsequence
	// ****************************************
	// Assertions
	// ****************************************
	AST_WAKE_DELAY: assert property (@(posedge MCLK) disable iff (!RESET_N) s_leave |-> s_ready)
		else $error("ready not raised after the wake delay");
	AST_QUIET_ASLEEP: assert property (@(posedge MCLK) disable iff (!RESET_N) (SLEEPING || IDLING) |-> !SDA_OE)
		else $error("data line pulled while not awake");
	AST_ONE_STATE: assert property (@(posedge MCLK) disable iff (!RESET_N) $onehot0({SLEEPING, IDLING, READY}))
		else $error("power states overlap");
	AST_OPEN_DRAIN: assert property (@(posedge LINK_CLK) disable iff (!RESET_N) SDA_OE |-> !SDA_OUT)
		else $error("data line driven high");
	AST_ACK_HOLD: assert property (@(posedge LINK_CLK) disable iff (!RESET_N) $rose(SDA_OE) |-> s_ack)
		else $error("acknowledge too short or not in clock low");
	AST_ACK_DROP: assert property (@(posedge LINK_CLK) disable iff (!RESET_N) $fell(SDA_OE) |-> !SCL_IN)
		else $error("acknowledge released while clock high");
	AST_START_BUSY: assert property (@(posedge MCLK) disable iff (!RESET_N) CMD_START |=> BUSY && !CMD_START)
		else $error("start pulse not followed by busy");
	AST_START_COUNT: assert property (@(posedge MCLK) disable iff (!RESET_N) CMD_START |-> CMD_LENGTH != 0)
		else $error("start with an empty buffer");
	AST_BUSY_HOLD: assert property (@(posedge MCLK) disable iff (!RESET_N) BUSY && !CMD_DONE |=> BUSY)
		else $error("busy dropped before done");
	AST_DONE_FREE: assert property (@(posedge MCLK) disable iff (!RESET_N) BUSY && CMD_DONE |-> ##[1:3] (!BUSY && CMD_LENGTH == 0))
		else $error("buffer not freed after done");
	AST_SLEEP_CLEAR: assert property (@(posedge MCLK) disable iff (!RESET_N) VOLATILE_CLEAR |-> ##[0:3] (SLEEPING && CMD_LENGTH == 0))
		else $error("sleep entry left state behind");
endmodule : se_client_properties
`default_nettype wire

// ### test/i2c_host_model.sv
// Behavioural bus host: clock and open-drain data
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
	output logic scl,
	output logic sda_drv,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// Long low with the clock parked high; slower than any data bit
	task automatic wake_pulse();
		sda_drv = 1'b0;
		#65000 sda_drv = 1'b1;
	endtask : wake_pulse
	task automatic start_c();
		sda_drv = 1'b0;
		#2000 scl = 1'b0;
	endtask : start_c
	task automatic stop_c();
		#500 sda_drv = 1'b0;
		#1500 scl = 1'b1;
		#2000 sda_drv = 1'b1;
		#2000;
	endtask : stop_c
	// Data moves only a quarter into clock low; the ninth bit is released for the answer
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic [8:0] f;
		f = {b, 1'b1};
		for (int i = 8; i >= 0; i--) begin
			#500 sda_drv = f[i];
			#1500 scl = 1'b1;
			ack = ~sda;
			#2000 scl = 1'b0;
		end
	endtask : send_byte
endmodule : i2c_host_model
`default_nettype wire

// ### test/secure_element_i2c_client_test.sv
// Self-checking bench for the secure element bus client
`timescale 1ns/1ps
`default_nettype none
module secure_element_i2c_client_test
	import se_client_pkg::*;
;
	localparam int WHC = 20;
	localparam logic [7:0] WR = {BUS_ADDRESS_RESET, 1'b0};
	logic mclk = 1'b0;
	logic link_clk = 1'b0;
	logic reset_n = 1'b0;
	logic cmd_done = 1'b0;
	logic [IDX_W-1:0] rd_index = '0;
	logic scl, host_sda, sda_out, sda_oe, cmd_start, busy, ready, sleeping, idling, vol_clear;
	logic [7:0] rd_data;
	logic [PTR_W-1:0] cmd_length;
	wire logic sda;
	int n_mismatch = 0;
	int compares = 0;
	int cycles = 0;
	int starts = 0;
	int clears = 0;
	// Pull-up: low only while a party pulls it
	assign sda = host_sda & ~(sda_oe & ~sda_out);
	always #50 mclk = ~mclk;
	always #62.5 link_clk = ~link_clk;
	secure_element_i2c_client #(.WAKE_HIGH_COUNT(WHC)) u_secure_element_i2c_client (
		.MCLK(mclk), .RESET_N(reset_n), .LINK_CLK(link_clk), .SCL_IN(scl), .SDA_IN(sda),
		.SDA_OUT(sda_out), .SDA_OE(sda_oe), .CMD_DONE(cmd_done), .CMD_RD_INDEX(rd_index),
		.CMD_RD_DATA(rd_data), .CMD_LENGTH(cmd_length), .CMD_START(cmd_start), .BUSY(busy),
		.READY(ready), .SLEEPING(sleeping), .IDLING(idling), .VOLATILE_CLEAR(vol_clear));
	i2c_host_model u_host (.scl(scl), .sda_drv(host_sda), .sda(sda));
	always @(posedge mclk) begin
		cycles++;
		starts += int'(cmd_start === 1'b1);
		clears += int'(vol_clear === 1'b1);
		if (cycles == 80000) begin
			fail("timeout");
			end_sim();
		end
	end
	// ****************************************
	// Helpers
	// ****************************************
	task automatic fail(input string msg);
		n_mismatch++;
		$display("[ERR] %0t %s", $time, msg);
	endtask : fail
	task automatic chk1(input logic got, input logic exp, input string msg);
		compares++;
		if (got !== exp) fail(msg);
	endtask : chk1
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
		compares++;
		if (got !== exp) fail(msg);
	endtask : chk8
	task automatic end_sim();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim
	// Sends n bytes taken from the low end of b, oldest first; counts acknowledges
	task automatic wr(input int n, input logic [39:0] b, output int acks);
		logic a;
		#10;
		acks = 0;
		u_host.start_c();
		for (int i = 0; i < n; i++) begin
			u_host.send_byte(b[8*(n-1-i) +: 8], a);
			acks += int'(a === 1'b1);
		end
		u_host.stop_c();
		repeat (10) @(posedge mclk);
	endtask : wr
	task automatic wake(output int n);
		#10;
		u_host.wake_pulse();
		n = 0;
		while (ready !== 1'b1 && n < 100) begin
			@(posedge mclk);
			#10;
			n++;
		end
		repeat (4) @(posedge mclk);
	endtask : wake
	task automatic rd(input int i, input logic [7:0] exp);
		@(posedge mclk);
		#10 rd_index = IDX_W'(i);
		@(posedge mclk);
		#10 chk8(rd_data, exp, "buffer byte");
	endtask : rd
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_wake();
		int n;
		int a;
		wr(2, {WR, WORD_COMMAND}, a);
		chk8(8'(a), 8'h00, "ack while asleep");
		wake(n);
		chk1(n >= WHC - 2 && n <= WHC + 6, 1'b1, "wake delay");
		wake(n);
		chk1(ready, 1'b1, "second wake disturbed ready");
		wr(2, {8'h62, WORD_COMMAND}, a);
		chk8(8'(a), 8'h00, "foreign address acked");
		wr(1, {8'h61}, a);
		chk8(8'(a), 8'h00, "read address acked");
	endtask : t_wake
	task automatic t_cmd();
		int a;
		int s0;
		s0 = starts;
		wr(4, {WR, WORD_COMMAND, 8'h04, 8'hA5}, a);
		chk8(8'(a), 8'h04, "write not acked");
		chk8(8'(cmd_length), 8'h02, "stored count");
		chk8(8'(starts - s0), 8'h00, "partial group started");
		wr(5, {WR, WORD_COMMAND, 8'h3C, 8'h5A, 8'h77}, a);
		chk8(8'(starts - s0), 8'h01, "group not started");
		chk1(busy, 1'b1, "not busy");
		wr(3, {WR, WORD_COMMAND, 8'h99}, a);
		chk8(8'(cmd_length), 8'h04, "bytes beyond count kept");
		for (int i = 0; i < 4; i++) rd(i, 8'(32'h04A53C5A >> (24 - 8 * i)));
		@(posedge mclk);
		#10 cmd_done = 1'b1;
		@(posedge mclk);
		#10 cmd_done = 1'b0;
		repeat (4) @(posedge mclk);
		chk1(busy, 1'b0, "busy after done");
	endtask : t_cmd
	task automatic t_modes();
		int a;
		int n;
		int c0;
		wr(4, {WR, WORD_COMMAND, 8'h05, 8'h11}, a);
		wr(2, {WR, WORD_RESET}, a);
		chk8(8'(cmd_length), 8'h00, "pointer not reset");
		wr(3, {WR, WORD_COMMAND, 8'h07}, a);
		rd(0, 8'h07);
		wr(2, {WR, WORD_IDLE}, a);
		chk1(idling, 1'b1, "not idle");
		wr(3, {WR, WORD_COMMAND, 8'h44}, a);
		chk8(8'(a), 8'h00, "traffic taken while idle");
		wake(n);
		chk8(8'(cmd_length), 8'h01, "idle lost buffer");
		c0 = clears;
		wr(2, {WR, WORD_SLEEP}, a);
		chk1(sleeping, 1'b1, "not asleep");
		chk8(8'(clears - c0), 8'h01, "no state clear");
		chk8(8'(cmd_length), 8'h00, "sleep kept buffer");
		rd(0, 8'h00);
		wr(1, {WR}, a);
		chk8(8'(a), 8'h00, "ack after sleep");
	endtask : t_modes
	initial begin
		repeat (5) @(posedge mclk);
		#10 reset_n = 1'b1;
		repeat (4) @(posedge mclk);
		t_wake();
		t_cmd();
		t_modes();
		end_sim();
	end
endmodule : secure_element_i2c_client_test
bind secure_element_i2c_client se_client_properties #(.WAKE_HIGH_COUNT(WAKE_HIGH_COUNT)) u_props (
	.MCLK(MCLK), .RESET_N(RESET_N), .LINK_CLK(LINK_CLK), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT),
	.SDA_OE(SDA_OE), .CMD_DONE(CMD_DONE), .CMD_LENGTH(CMD_LENGTH), .CMD_START(CMD_START), .BUSY(BUSY),
	.READY(READY), .SLEEPING(SLEEPING), .IDLING(IDLING), .VOLATILE_CLEAR(VOLATILE_CLEAR));
`default_nettype wire
